/* clk_ctrl_pkg.sv */
// shared constants for the clock multiplier control block
package clk_ctrl_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_CODE   = 4'h8;
   // control register fields
   localparam int CTRL_MULT_BIT   = 0;
   localparam int CTRL_OVR_BIT    = 1;
   localparam int CTRL_RELOCK_BIT = 2;
   localparam int CTRL_CALRST_BIT = 3;
   localparam int CTRL_RANGE_LSB  = 4;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0008;
   localparam logic [31:0] CTRL_WR_MASK = 32'h0000_00ff;
   // status register fields
   localparam int STAT_MODE_LSB   = 0;
   localparam int STAT_STATE_LSB  = 2;
   localparam int STAT_LOCK_BIT   = 4;
   localparam int STAT_ERR_BIT    = 5;
   localparam int STAT_RAW_BIT    = 6;
   localparam int STAT_RANGE_LSB  = 8;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // timing: clock rate and printed durations
   localparam int CLK_MHZ         = 250;
   localparam int CAL_TIME_MS     = 180;
   localparam int RELOCK_TIME_US  = 250;
   localparam int CAL_CYCLES      = CAL_TIME_MS * 1000 * CLK_MHZ;
   localparam int RELOCK_CYCLES   = RELOCK_TIME_US * CLK_MHZ;
   localparam int CAL_STEPS       = 64;
   localparam int FILTER_CYCLES   = 64;
   localparam int CNT_W           = 26;
   localparam int RANGE_W         = 6;
   localparam logic [RANGE_W-1:0] CODE_LAST = 6'h3f;
   // operating modes
   typedef enum logic [1:0] {
      MODE_CAL_ONCE = 2'b00,
      MODE_RELOCK   = 2'b01,
      MODE_MANUAL   = 2'b10
   } mode_t;
   // calibration sequencer states
   typedef enum logic [1:0] {
      ST_CAL    = 2'b00,
      ST_ACQ    = 2'b01,
      ST_LOCK   = 2'b10,
      ST_MANUAL = 2'b11
   } seq_state_t;
endpackage

/* lock_filter.sv */
// debounce filter for the raw loop lock indication
`timescale 1ns/10ps
module lock_filter (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic raw_lock,
   output logic      filt_lock
);
   logic [6:0] run_q, run_d;   // cycles raw has disagreed with output
   logic       filt_q, filt_d; // filtered level

   // output only flips after raw disagrees for a full window
   always_comb begin
      run_d  = run_q;
      filt_d = filt_q;
      if (raw_lock == filt_q) begin
         run_d = 7'h00;
      end else if (run_q == 7'(clk_ctrl_pkg::FILTER_CYCLES - 1)) begin
         filt_d = raw_lock; // R9
         run_d  = 7'h00;
      end else begin
         run_d = run_q + 7'h01;
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q  <= 7'h00;
         filt_q <= 1'b0;
      end else begin
         run_q  <= run_d;
         filt_q <= filt_d;
      end
   end

   assign filt_lock = filt_q;

   chk_filter_holds: assert property (@(posedge clk) disable iff (!rst_n) // R9
      (raw_lock != filt_q && run_q != 7'(clk_ctrl_pkg::FILTER_CYCLES - 1))
      ##1 (raw_lock == filt_q) |-> $stable(filt_q))
      else $error("filtered lock flipped on a short glitch");
endmodule // lock_filter

/* tmr_reg.sv */
// triplicated register with majority vote and upset flag
`timescale 1ns/10ps
module tmr_reg #(
   parameter int         W     = 8,
   parameter logic [7:0] RST_V = 8'h00
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic              err
);
   logic [W-1:0] copy_q [3]; // three independent copies

   // each copy reloads the voted next value, so an upset heals in one edge
   for (genvar i = 0; i < 3; i++) begin : g_copy
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            copy_q[i] <= RST_V[W-1:0];
         end else begin
            copy_q[i] <= d;
         end
      end
   end

   // bitwise majority and disagreement flag
   always_comb begin
      q   = (copy_q[0] & copy_q[1]) | (copy_q[1] & copy_q[2]) | (copy_q[0] & copy_q[2]); // R11
      err = (copy_q[0] != copy_q[1]) || (copy_q[1] != copy_q[2]); // R11
   end

   chk_vote_flag: assert property (@(posedge clk) disable iff (!rst_n) // R11
      (copy_q[0] != copy_q[2]) |-> err)
      else $error("copies disagree without error flag");
endmodule // tmr_reg

/* clk_mult_ctrl.sv */
// control logic of the crystal based jitter filtering clock multiplier
// Notes on behaviour
// [R1] mult select low 40/60/120, high 40/80/160
// [R2] top clock from crystal, others divided synchronously
// [R3] two references ORed; unused one held low
// [R4] auto mode calibrates after reset and loss; the code recalibrates on loss only with relock set
// [R5] override disables calibration, range from select bits
// [R6] override maps relock to bit4, reset to bit5
// [R7] unlock with relock enabled restarts calibration
// [R8] relock disabled: calibrate only after reset
// [R9] no override: lock output is filtered
// [R10] override: lock output is raw indication
// [R11] redundant state corrects upsets, error flags briefly
// [R12] mode decode: 00->0, 01->1, 1x->2
// [R13] mode 0 keeps calibration, fast relock
// [R14] mode 0: host resets if lock not regained
// [R15] mode 1 full calibration after reset or loss
// [R16] range select bus is six bits
// [R17] mode 2 keeps calibration logic idle
// [R18] calibration reset low restarts calibration
// [R19] mode 2 reference acts as extreme select
// [R20] sequencing initialised by calibration reset
`timescale 1ns/10ps
module clk_mult_ctrl #(
   parameter int CAL_CYCLES    = clk_ctrl_pkg::CAL_CYCLES,
   parameter int RELOCK_CYCLES = clk_ctrl_pkg::RELOCK_CYCLES
) (
   input  wire logic        MCLK,
   input  wire logic        RESETN,
   input  wire logic [3:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [3:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic        REF_CMOS,
   input  wire logic        REF_LVDS,
   input  wire logic        RAW_LOCK,
   output logic             CLK_HIGH,
   output logic             CLK_MID,
   output logic             CLK_LOW,
   output logic             REF_OUT,
   output logic             EDGE_SEL,
   output logic [5:0]       RANGE_SEL,
   output logic             CAL_ACTIVE,
   output logic             LOCKED,
   output logic             ERROR
);
   localparam int STEP_CYCLES = CAL_CYCLES / clk_ctrl_pkg::CAL_STEPS;
   localparam int CNT_W_L     = clk_ctrl_pkg::CNT_W;

   // sequencer state, declared early because the bus reads the code
   clk_ctrl_pkg::seq_state_t st_v, st_n;   // voted and next state
   logic [5:0]      code_v, code_n;        // voted and next range code
   logic [CNT_W_L-1:0] cnt_q, cnt_d;       // step and timeout counter
   logic            filt;                  // filtered lock
   logic            upset;                 // redundancy mismatch
   logic [7:0]      seq_v;                 // voted word

   // decode a byte address into a register slot, 3 means unmapped
   function automatic logic [1:0] reg_slot(input logic [3:0] a);
      case (a)
         clk_ctrl_pkg::OFF_CTRL:   reg_slot = 2'h0;
         clk_ctrl_pkg::OFF_STATUS: reg_slot = 2'h1;
         clk_ctrl_pkg::OFF_CODE:   reg_slot = 2'h2;
         default:                  reg_slot = 2'h3;
      endcase
   endfunction

   // operating mode from override and relock inputs
   function automatic clk_ctrl_pkg::mode_t decode_mode(input logic ovr, input logic rel);
      if (ovr) begin
         decode_mode = clk_ctrl_pkg::MODE_MANUAL; // R12
      end else if (rel) begin
         decode_mode = clk_ctrl_pkg::MODE_RELOCK; // R12
      end else begin
         decode_mode = clk_ctrl_pkg::MODE_CAL_ONCE; // R12
      end
   endfunction

   // ---------------- register bus ----------------
   logic        aw_q, aw_d;        // write address held
   logic [3:0]  awa_q, awa_d;      // latched write address
   logic        w_q, w_d;          // write data held
   logic [31:0] wd_q, wd_d;        // latched write data
   logic [3:0]  ws_q, ws_d;        // latched strobes
   logic        bv_q, bv_d;        // write response pending
   logic [1:0]  br_q, br_d;        // write response code
   logic        rv_q, rv_d;        // read response pending
   logic [31:0] rd_q, rd_d;        // read data
   logic [1:0]  rr_q, rr_d;        // read response code
   logic [31:0] ctrl_q, ctrl_d;    // control register
   logic [31:0] status_w;          // assembled status word

   // control fields
   logic mult, ovr, relock, cal_rst_n;
   logic [3:0] range_lo;
   assign mult      = ctrl_q[clk_ctrl_pkg::CTRL_MULT_BIT];
   assign ovr       = ctrl_q[clk_ctrl_pkg::CTRL_OVR_BIT];
   assign relock    = ctrl_q[clk_ctrl_pkg::CTRL_RELOCK_BIT];
   assign cal_rst_n = ctrl_q[clk_ctrl_pkg::CTRL_CALRST_BIT];
   assign range_lo  = ctrl_q[clk_ctrl_pkg::CTRL_RANGE_LSB +: 4];

   // each channel stalls while its item waits or a response is unaccepted
   assign AWREADY = !aw_q && !bv_q;
   assign WREADY  = !w_q && !bv_q;
   assign ARREADY = !rv_q;

   // bus next state: address and data in either order, write once both held
   always_comb begin
      aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
      bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
      ctrl_d = ctrl_q;
      if (AWVALID && AWREADY) begin
         aw_d  = 1'b1;
         awa_d = AWADDR;
      end
      if (WVALID && WREADY) begin
         w_d  = 1'b1;
         wd_d = WDATA;
         ws_d = WSTRB;
      end
      if (aw_q && w_q) begin
         // only the control slot is writable, unmapped addresses answer decode error
         for (int b = 0; b < 4; b++) begin
            if (reg_slot(awa_q) == 2'h0 && ws_q[b]) begin
               ctrl_d[b*8 +: 8] = wd_q[b*8 +: 8] & clk_ctrl_pkg::CTRL_WR_MASK[b*8 +: 8];
            end
         end
         br_d = (reg_slot(awa_q) == 2'h3) ? clk_ctrl_pkg::RESP_DECERR : clk_ctrl_pkg::RESP_OKAY;
         bv_d = 1'b1;
         aw_d = 1'b0;
         w_d  = 1'b0;
      end else if (bv_q && BREADY) begin
         bv_d = 1'b0;
      end
      if (ARVALID && ARREADY) begin
         rv_d = 1'b1;
         rr_d = clk_ctrl_pkg::RESP_OKAY;
         case (reg_slot(ARADDR))
            2'h0:    rd_d = ctrl_q;
            2'h1:    rd_d = status_w;
            2'h2:    rd_d = {26'h0, code_v};
            default: begin
               rd_d = 32'h0;
               rr_d = clk_ctrl_pkg::RESP_DECERR;
            end
         endcase
      end else if (rv_q && RREADY) begin
         rv_d = 1'b0;
      end
   end

   // bus registers
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         aw_q <= 1'b0; awa_q <= 4'h0; w_q <= 1'b0; wd_q <= 32'h0; ws_q <= 4'h0;
         bv_q <= 1'b0; br_q <= 2'h0; rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= 2'h0;
         ctrl_q <= clk_ctrl_pkg::CTRL_RESET;
      end else begin
         aw_q <= aw_d; awa_q <= awa_d; w_q <= w_d; wd_q <= wd_d; ws_q <= ws_d;
         bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign BVALID = bv_q;
   assign BRESP  = br_q;
   assign RVALID = rv_q;
   assign RDATA  = rd_q;
   assign RRESP  = rr_q;

   // ---------------- output clock plan ----------------
   logic [1:0] div_q, div_d;   // shared divider phase
   logic       mid_q, mid_d;   // half rate output
   logic       low_q, low_d;   // lowest rate output

   // mid is always half the crystal; low is a third or a quarter
   always_comb begin
      if (mult) begin
         div_d = div_q + 2'h1; // R1
      end else begin
         div_d = (div_q >= 2'h2) ? 2'h0 : div_q + 2'h1; // R1
      end
      mid_d = !mid_q; // R2
      low_d = mult ? div_d[1] : (div_d == 2'h0); // R2
   end

   // clock divider registers
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         div_q <= 2'h0;
         mid_q <= 1'b0;
         low_q <= 1'b0;
      end else begin
         div_q <= div_d;
         mid_q <= mid_d;
         low_q <= low_d;
      end
   end

   assign CLK_HIGH = MCLK; // R2
   assign CLK_MID  = mid_q;
   assign CLK_LOW  = low_q;

   // ---------------- calibration sequencer ----------------

   lock_filter u_filt (
      .clk       (MCLK),
      .rst_n     (RESETN),
      .raw_lock  (RAW_LOCK),
      .filt_lock (filt)
   );

   // state and code held in triplicate against upsets
   tmr_reg #(.W(8), .RST_V(8'h00)) u_tmr (
      .clk   (MCLK),
      .rst_n (RESETN),
      .d     ({st_n, code_n}),
      .q     (seq_v),
      .err   (upset)
   );
   assign st_v   = clk_ctrl_pkg::seq_state_t'(seq_v[7:6]);
   assign code_v = seq_v[5:0];

   // reset enters calibration; mode decides what loss of lock does
   always_comb begin
      st_n   = st_v;
      code_n = code_v;
      cnt_d  = cnt_q + CNT_W_L'(1);
      if (ovr) begin
         st_n  = clk_ctrl_pkg::ST_MANUAL; // R5 R17
         cnt_d = '0;
      end else if (!cal_rst_n) begin
         st_n   = clk_ctrl_pkg::ST_CAL; // R18 R20 R4
         code_n = 6'h00;
         cnt_d  = '0;
      end else begin
         case (st_v)
            clk_ctrl_pkg::ST_CAL: begin
               // sweep range codes until the loop reports lock or the last code is reached
               if (cnt_q == CNT_W_L'(STEP_CYCLES - 1)) begin
                  cnt_d = '0;
                  if (RAW_LOCK || code_v == clk_ctrl_pkg::CODE_LAST) begin
                     st_n = clk_ctrl_pkg::ST_ACQ;
                  end else begin
                     code_n = code_v + 6'h01;
                  end
               end
            end
            clk_ctrl_pkg::ST_ACQ: begin
               // mode 0 waits here until filtered lock returns, else the host must reset
               if (filt) begin
                  st_n  = clk_ctrl_pkg::ST_LOCK;
                  cnt_d = '0;
               end else if (relock && cnt_q == CNT_W_L'(RELOCK_CYCLES - 1)) begin
                  st_n   = clk_ctrl_pkg::ST_CAL; // R15
                  code_n = 6'h00;
                  cnt_d  = '0;
               end
            end
            clk_ctrl_pkg::ST_LOCK: begin
               cnt_d = '0;
               if (!filt && relock) begin
                  st_n   = clk_ctrl_pkg::ST_CAL; // R7 R15
                  code_n = 6'h00;
               end else if (!filt) begin
                  st_n = clk_ctrl_pkg::ST_ACQ; // R8 R13
               end
            end
            clk_ctrl_pkg::ST_MANUAL: begin
               st_n   = clk_ctrl_pkg::ST_CAL; // R4
               code_n = 6'h00;
               cnt_d  = '0;
            end
            default: begin
               st_n  = clk_ctrl_pkg::ST_CAL;
               cnt_d = '0;
            end
         endcase
      end
   end

   // ---------------- pin outputs ----------------
   logic       ref_q, ref_d;       // combined reference
   logic       edge_q, edge_d;     // extreme select in mode 2
   logic [5:0] range_q, range_d;   // oscillator range select
   logic       cal_q, cal_d;       // calibration running
   logic       lock_q, lock_d;     // lock output
   logic       err_q, err_d;       // upset flag
   logic       ovr_seen;           // override as decoded from the mode for the pin outputs
   clk_ctrl_pkg::mode_t mode;

   assign mode     = decode_mode(ovr, relock);
   assign ovr_seen = (mode == clk_ctrl_pkg::MODE_MANUAL);

   // output values; manual mode reuses relock and reset as top range bits
   always_comb begin
      ref_d   = REF_CMOS | REF_LVDS; // R3
      edge_d  = ovr_seen & (REF_CMOS | REF_LVDS); // R19
      range_d = ovr_seen ? {cal_rst_n, relock, range_lo} : code_n; // R6 R16
      cal_d   = (st_n == clk_ctrl_pkg::ST_CAL);
      lock_d  = ovr_seen ? RAW_LOCK : filt; // R9 R10
      err_d   = upset; // R11
   end

   // output registers
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ref_q <= 1'b0; edge_q <= 1'b0; range_q <= 6'h00;
         cal_q <= 1'b0; lock_q <= 1'b0; err_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         ref_q <= ref_d; edge_q <= edge_d; range_q <= range_d;
         cal_q <= cal_d; lock_q <= lock_d; err_q <= err_d;
         cnt_q <= cnt_d;
      end
   end

   assign REF_OUT    = ref_q;
   assign EDGE_SEL   = edge_q;
   assign RANGE_SEL  = range_q;
   assign CAL_ACTIVE = cal_q;
   assign LOCKED     = lock_q;
   assign ERROR      = err_q;

   always_comb begin
      status_w = 32'h0;
      status_w[clk_ctrl_pkg::STAT_MODE_LSB +: 2]    = mode;
      status_w[clk_ctrl_pkg::STAT_STATE_LSB +: 2]   = st_v;
      status_w[clk_ctrl_pkg::STAT_LOCK_BIT]         = lock_q;
      status_w[clk_ctrl_pkg::STAT_ERR_BIT]          = err_q;
      status_w[clk_ctrl_pkg::STAT_RAW_BIT]          = RAW_LOCK;
      status_w[clk_ctrl_pkg::STAT_RANGE_LSB +: 6]   = range_q;
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   sequence low_rise_x4;
      (mult && $rose(CLK_LOW)) ##1 (mult && !$rose(CLK_LOW)) [*3];
   endsequence

   chk_low_quarter_rate: assert property (low_rise_x4 ##1 mult |-> $rose(CLK_LOW)) // R1
      else $error("lowest clock not a quarter of the crystal");
   chk_ref_or_path: assert property (##1 REF_OUT == ($past(REF_CMOS) | $past(REF_LVDS))) // R3
      else $error("reference path is not the OR of both inputs");
   chk_override_manual: assert property (ovr |=> st_v == clk_ctrl_pkg::ST_MANUAL && !CAL_ACTIVE) // R5 R17
      else $error("override did not stop calibration");
   chk_manual_range_map: assert property (ovr |=> RANGE_SEL == $past({cal_rst_n, relock, range_lo})) // R6
      else $error("manual range bits mismapped");
   chk_calreset_restart: assert property ((!ovr && !cal_rst_n) |=> st_v == clk_ctrl_pkg::ST_CAL && code_v == 6'h00) // R18
      else $error("calibration reset did not restart calibration");
   chk_loss_relock_cal: assert property ((!ovr && cal_rst_n && relock && st_v == clk_ctrl_pkg::ST_LOCK && !filt)
      |=> st_v == clk_ctrl_pkg::ST_CAL) // R7 R15
      else $error("loss of lock with relock did not recalibrate");
   chk_loss_no_cal: assert property ((!ovr && cal_rst_n && !relock && st_v == clk_ctrl_pkg::ST_LOCK && !filt)
      |=> st_v == clk_ctrl_pkg::ST_ACQ) // R8 R13
      else $error("loss of lock without relock recalibrated");
   chk_lock_source: assert property (ovr |=> LOCKED == $past(RAW_LOCK)) // R10
      else $error("override lock output not raw");
   chk_lock_filtered: assert property (!ovr |=> LOCKED == $past(filt)) // R9
      else $error("lock output not filtered");
   chk_error_brief: assert property (upset |=> ERROR) // R11
      else $error("upset not flagged");
endmodule // clk_mult_ctrl

/* board_ref_model.sv */
// board side model: reference inputs and the loop's raw lock indication
`timescale 1ns/10ps
module board_ref_model (
   input  wire logic       clk,      // system clock
   input  wire logic       ref_lvl,  // wanted reference level
   input  wire logic       use_lvds, // pick the differential input
   input  wire logic       lock_en,  // loop allowed to settle
   input  wire logic [7:0] lock_dly, // settle time, 0 for prompt
   output logic            ref_cmos, // single ended reference
   output logic            ref_lvds, // differential reference
   output logic            raw_lock  // unfiltered loop lock
);
   logic [7:0] cnt_q; // cycles since lock allowed
   logic [7:0] cnt_d; // next count

   // unused input held low so the internal OR sees only the chosen one
   always_ff @(posedge clk) begin
      ref_cmos <= ref_lvl & ~use_lvds;
      ref_lvds <= ref_lvl & use_lvds;
   end

   // count up to the settle time, clear when lock is withdrawn
   always_comb begin
      cnt_d = cnt_q;
      if (!lock_en)
         cnt_d = 8'h00;
      else if (cnt_q != lock_dly)
         cnt_d = cnt_q + 8'h01;
   end

   // registered count only
   always_ff @(posedge clk) begin
      cnt_q <= cnt_d;
   end

   // lock drops at once but rises only after the settle time
   assign raw_lock = lock_en && (cnt_q == lock_dly);
endmodule // board_ref_model

/* clk_mult_ctrl_tb_top.sv */
// self-checking bench for the clock multiplier control block
`timescale 1ns/10ps
module clk_mult_ctrl_tb_top;
   logic        MCLK, RESETN;                   // clock, async reset
   logic [3:0]  AWADDR, ARADDR, WSTRB;          // bus address, lanes
   logic [31:0] WDATA, RDATA;                   // bus data
   logic        AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [1:0]  BRESP, RRESP;                   // bus answers
   logic        REF_CMOS, REF_LVDS, RAW_LOCK, REF_OUT, EDGE_SEL;
   logic        CLK_HIGH, CLK_MID, CLK_LOW, CAL_ACTIVE, LOCKED, ERROR;
   logic [5:0]  RANGE_SEL;                      // oscillator range
   logic        ref_lvl, use_lvds, lock_en;     // partner controls
   logic [7:0]  lock_dly;                       // partner settle time
   int          num_errors, n_compared;         // verdict counters

   // short calibration so a full sweep is 640 cycles
   clk_mult_ctrl #(.CAL_CYCLES(640), .RELOCK_CYCLES(100)) uut (.*);
   board_ref_model partner (.clk(MCLK), .ref_lvl(ref_lvl), .use_lvds(use_lvds),
      .lock_en(lock_en), .lock_dly(lock_dly), .ref_cmos(REF_CMOS),
      .ref_lvds(REF_LVDS), .raw_lock(RAW_LOCK));

   // 250 MHz clock
   always #2 MCLK = ~MCLK;

   // one counted comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   // settle to a falling edge before looking
   task automatic cyc(input int n);
      repeat (n) @(negedge MCLK);
   endtask

   // write: both channels offered, each released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int   i;
      logic aw, w, b;
      logic [1:0] r;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      b = 1'b0;
      for (i = 0; i < 50 && !b; i++) begin
         @(negedge MCLK);
         aw = AWVALID && AWREADY === 1'b1;
         w = WVALID && WREADY === 1'b1;
         b = BVALID === 1'b1;
         r = BRESP;
         @(posedge MCLK);
         if (aw) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
      end
      BREADY <= 1'b0;
      chk("write answer", 1, b);
      chk("write resp", er, r);
   endtask

   // read and compare the masked word
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
      int   i;
      logic ar, v;
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      v = 1'b0;
      for (i = 0; i < 50 && !v; i++) begin
         @(negedge MCLK);
         ar = ARVALID && ARREADY === 1'b1;
         v = RVALID === 1'b1;
         d = RDATA;
         r = RRESP;
         @(posedge MCLK);
         if (ar) ARVALID <= 1'b0;
      end
      RREADY <= 1'b0;
      chk("read answer", 1, v);
      chk("read resp", er, r);
      chk("read data", e, d & m);
   endtask

   // control register write
   task automatic wctl(input logic [31:0] d);
      wr(clk_ctrl_pkg::OFF_CTRL, d, clk_ctrl_pkg::RESP_OKAY);
   endtask

   // status read, masked
   task automatic rst(input logic [31:0] m, input logic [31:0] e);
      rd(clk_ctrl_pkg::OFF_STATUS, m, e, clk_ctrl_pkg::RESP_OKAY);
   endtask

   // reset values, unmapped place, read-only upper bits
   task automatic t_reset();
      cyc(2);
      chk("cal after reset", 1, CAL_ACTIVE);
      rd(clk_ctrl_pkg::OFF_CTRL, 32'hffff_ffff, 32'h08, clk_ctrl_pkg::RESP_OKAY);
      wr(4'hc, 32'h0, clk_ctrl_pkg::RESP_DECERR);
      rd(4'hc, 32'hffff_ffff, 32'h0, clk_ctrl_pkg::RESP_DECERR);
      wctl(32'habcd_0008);
      rd(clk_ctrl_pkg::OFF_CTRL, 32'hffff_ffff, 32'h08, clk_ctrl_pkg::RESP_OKAY);
      rst(32'h3, 32'h0);
   endtask

   // divided clocks for both multiplication selects
   task automatic t_clocks();
      int          m;
      logic [31:0] lo, mid;
      for (m = 0; m < 2; m++) begin
         wctl(32'h08 | m);
         cyc(4);
         lo = 0;
         mid = 0;
         repeat (12) begin
            @(negedge MCLK);
            lo = lo + CLK_LOW;
            mid = mid + CLK_MID;
         end
         chk("low clock highs", m ? 6 : 4, lo);
         chk("mid clock highs", 6, mid);
         #1 chk("crystal clock", 0, CLK_HIGH);
      end
      wctl(32'h08);
   endtask

   // both references pass through the OR, edge select idle outside manual
   task automatic t_refs();
      int i;
      for (i = 0; i < 4; i++) begin
         @(posedge MCLK);
         use_lvds <= i[0];
         ref_lvl <= i[1];
         cyc(3);
         chk("reference or", i[1], REF_OUT);
         chk("edge idle", 0, EDGE_SEL);
      end
      @(posedge MCLK);
      ref_lvl <= 1'b0;
   endtask

   // relock mode: slow partner, loss restarts calibration
   task automatic t_mode1();
      int i;
      wctl(32'h04);
      cyc(2);
      chk("cal on sw reset", 1, CAL_ACTIVE);
      rd(clk_ctrl_pkg::OFF_CODE, 32'hffff_ffff, 32'h0, clk_ctrl_pkg::RESP_OKAY);
      wctl(32'h0c);
      @(posedge MCLK);
      lock_dly <= 8'd20;
      lock_en <= 1'b1;
      for (i = 0; i < 900 && LOCKED !== 1'b1; i++) @(negedge MCLK);
      chk("mode1 locked", 1, LOCKED);
      rst(32'h7f, 32'h59);
      @(posedge MCLK);
      lock_en <= 1'b0;
      cyc(30);
      chk("filtered hold", 1, LOCKED);
      for (i = 0; i < 200 && CAL_ACTIVE !== 1'b1; i++) @(negedge MCLK);
      chk("relock cal", 1, CAL_ACTIVE);
   endtask

   // calibrate-once mode: loss keeps settings, host forces recalibration
   task automatic t_mode0();
      int i;
      wctl(32'h08);
      @(posedge MCLK);
      lock_en <= 1'b1;
      for (i = 0; i < 900 && LOCKED !== 1'b1; i++) @(negedge MCLK);
      chk("mode0 locked", 1, LOCKED);
      rst(32'h7f, 32'h58);
      @(posedge MCLK);
      lock_en <= 1'b0;
      cyc(150);
      chk("no cal on loss", 0, CAL_ACTIVE);
      rst(32'h7f, 32'h04);
      @(posedge MCLK);
      lock_en <= 1'b1;
      for (i = 0; i < 200 && LOCKED !== 1'b1; i++) @(negedge MCLK);
      chk("fast relock", 0, CAL_ACTIVE);
      @(posedge MCLK);
      lock_en <= 1'b0;
      wctl(32'h00);
      cyc(2);
      chk("cal on host reset", 1, CAL_ACTIVE);
   endtask

   // manual override: range pins, raw lock, reference as extreme select
   task automatic t_manual();
      int i;
      for (i = 0; i < 2; i++) begin
         wctl(i ? 32'h52 : 32'h5e);
         cyc(3);
         chk("range select", i ? 6'h05 : 6'h35, RANGE_SEL);
         chk("cal idle", 0, CAL_ACTIVE);
         rst(32'hf, 32'he);
      end
      @(posedge MCLK);
      ref_lvl <= 1'b1;
      lock_dly <= 8'd0;
      lock_en <= 1'b1;
      cyc(3);
      chk("edge select high", 1, EDGE_SEL);
      chk("raw lock high", 1, LOCKED);
      @(posedge MCLK);
      ref_lvl <= 1'b0;
      lock_en <= 1'b0;
      cyc(3);
      chk("edge select low", 0, EDGE_SEL);
      chk("raw lock low", 0, LOCKED);
      wctl(32'h0c);
      cyc(3);
      chk("cal after override", 1, CAL_ACTIVE);
   endtask

   // verdict and end of run
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // bound far above the several hundred cycles the tests take
   initial begin
      #80000;
      num_errors++;
      summarize();
   end

   // reset for three cycles, then the scenarios
   initial begin
      MCLK = 1'b0;
      RESETN = 1'b0;
      {AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hf;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      {ref_lvl, use_lvds, lock_en} = '0;
      lock_dly = 8'd0;
      num_errors = 0;
      n_compared = 0;
      repeat (3) @(posedge MCLK);
      RESETN <= 1'b1;
      t_reset();
      t_clocks();
      t_refs();
      t_mode1();
      t_mode0();
      t_manual();
      chk("upset flag", 0, ERROR);
      summarize();
   end
endmodule // clk_mult_ctrl_tb_top
